/* tkp_pkg.sv */
// Shared constants for the touch and keypad serial host port
//------------------------------------------------------------------------------
// Contract
// - Ignore serial input while select is high
// - Serial output floats while select is high
// - Sample input bits on serial clock fall
// - Shift output bits on serial clock fall
// - Registers 16 bits, command word first
// - Result ready low on conversion done
// - Key interrupt low on key press
// - Touch interrupt on screen touch
// - Results stored, readable at any time
// - Control registers steer converter, DAC, scanner
//------------------------------------------------------------------------------
package tkp_pkg;

    //--------------------------------------------------------------------------
    // Word and map geometry
    //--------------------------------------------------------------------------
    localparam int              DATA_W       = 16;
    localparam int              ADDR_W       = 4;
    localparam int              REG_NUM      = 16;
    localparam int              FIFO_W       = 17;  // Frame-start flag plus word
    localparam int              FIFO_DEPTH   = 8;
    localparam int              CMD_READ_BIT = 15;  // 1 reads, 0 writes
    localparam int              FIRST_BIT    = 16;  // Flag position in FIFO word

    //--------------------------------------------------------------------------
    // Register indices and reset values
    //--------------------------------------------------------------------------
    localparam logic [3:0]      ADC_CTRL_IDX = 4'h0;
    localparam logic [3:0]      DAC_CTRL_IDX = 4'h1;
    localparam logic [3:0]      KEY_CTRL_IDX = 4'h2;
    localparam logic [3:0]      KEY_CODE_IDX = 4'h3;
    localparam logic [3:0]      RES_BASE_IDX = 4'h8;  // Results sit at 8..15
    localparam logic [15:0]     REG_RST      = 16'h0000;
    localparam logic [3:0]      BIT_CNT_RST  = 4'h0;
    localparam logic [3:0]      BIT_LAST     = 4'hF;

    //--------------------------------------------------------------------------
    // Frame state on the system clock side
    //--------------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ  = 3'b100
    } frame_state_e;

endpackage : tkp_pkg

/* tkp_word_fifo.sv */
// Word FIFO between the link capture and the register map
`timescale 1ns/10ps
module tkp_word_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW:0]      wrPtr_r;
    logic [PW:0]      rdPtr_r;
    logic             full;
    logic             empty;

    //--------------------------------------------------------------------------
    // Status: extra pointer bit tells full from empty
    //--------------------------------------------------------------------------
    assign full     = (wrPtr_r[PW] != rdPtr_r[PW]) &&
                      (wrPtr_r[PW-1:0] == rdPtr_r[PW-1:0]);
    assign empty    = (wrPtr_r == rdPtr_r);
    assign inReady  = !full;
    assign outValid = !empty;
    assign outData  = mem_r[rdPtr_r[PW-1:0]];

    // Storage is not reset; only the pointers define content
    always_ff @(posedge clk) begin
        if (inValid && !full) begin
            mem_r[wrPtr_r[PW-1:0]] <= inData;
        end
    end

    // Write pointer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrPtr_r <= '0;
        end else if (inValid && !full) begin
            wrPtr_r <= wrPtr_r + 1'b1;
        end
    end

    // Read pointer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdPtr_r <= '0;
        end else if (outReady && !empty) begin
            rdPtr_r <= rdPtr_r + 1'b1;
        end
    end

endmodule : tkp_word_fifo

/* touch_keypad_serial_host_port.sv */
// Serial slave port, register map and event outputs of the touch interface
`timescale 1ns/10ps
module touch_keypad_serial_host_port
    import tkp_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              nrst,
    input  wire logic              sclk,
    input  wire logic              ssN,
    input  wire logic              mosi,
    output logic                   misoOut,
    output logic                   misoOeN,
    input  wire logic              convDone,
    input  wire logic              keyHit,
    input  wire logic              touchIn,
    input  wire logic              resWe,
    input  wire logic [ADDR_W-1:0] resAddr,
    input  wire logic [DATA_W-1:0] resData,
    output logic [DATA_W-1:0]      adcCtrl,
    output logic [DATA_W-1:0]      dacCtrl,
    output logic [DATA_W-1:0]      keyCtrl,
    output logic                   resultReadyN,
    output logic                   keyPressIrqN,
    output logic                   touchDetectIrq
);

    //--------------------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------------------
    logic [3:0]        bitCnt_r;
    logic [DATA_W-1:0] shIn_r;
    logic [DATA_W-1:0] shOut_r;
    logic [DATA_W-1:0] wordHold_r;
    logic              firstPend_r;
    logic              holdFirst_r;
    logic              wordTog_r;
    logic [2:0]        togSync_r;
    logic              wordEv;
    logic              pendV_r;
    logic [FIFO_W-1:0] pendData_r;
    logic              fifoInReady;
    logic              fifoOutValid;
    logic [FIFO_W-1:0] fifoOut;
    logic              drainReady;
    logic              take;
    logic              isFirst;
    logic [DATA_W-1:0] hostWord;
    logic              hostWe;
    frame_state_e      state_r;
    logic [ADDR_W-1:0] ptr_r;
    logic [ADDR_W-1:0] shipAddr_r;
    logic              armed_r;
    logic              shipClr;
    logic [DATA_W-1:0] rdWord_r;
    logic [DATA_W-1:0] regs_r [REG_NUM];
    logic              dataRdy_r;
    logic              keyFlag_r;
    logic              touch_r;

    //--------------------------------------------------------------------------
    // Link domain: runs on the host's serial clock
    //--------------------------------------------------------------------------
    // Deselect holds the counter in reset, so no bit is taken while high
    always_ff @(negedge sclk or posedge ssN) begin
        if (ssN) begin
            bitCnt_r    <= BIT_CNT_RST;
            firstPend_r <= 1'b1;
            shIn_r      <= REG_RST;
        end else begin
            shIn_r   <= {shIn_r[DATA_W-2:0], mosi};
            bitCnt_r <= bitCnt_r + 4'h1;
            if (bitCnt_r == BIT_LAST) begin
                firstPend_r <= 1'b0;
            end
        end
    end

    // Output shifter; reloads at each word boundary from the prefetch word
    always_ff @(negedge sclk or posedge ssN) begin
        if (ssN) begin
            shOut_r <= REG_RST;
        end else if (bitCnt_r == BIT_LAST) begin
            shOut_r <= rdWord_r;
        end else begin
            shOut_r <= {shOut_r[DATA_W-2:0], 1'b0};
        end
    end

    // Completed word is held until the next one, so deselect cannot
    // wipe it before the system side has picked it up
    always_ff @(negedge sclk or negedge nrst) begin
        if (!nrst) begin
            wordHold_r  <= REG_RST;
            holdFirst_r <= 1'b0;
            wordTog_r   <= 1'b0;
        end else if (!ssN && bitCnt_r == BIT_LAST) begin
            wordHold_r  <= {shIn_r[DATA_W-2:0], mosi};
            holdFirst_r <= firstPend_r;
            wordTog_r   <= ~wordTog_r;
        end
    end

    // Output floats whenever the device is not selected
    assign misoOut = shOut_r[DATA_W-1];
    assign misoOeN = ssN;

    //--------------------------------------------------------------------------
    // Crossing: word toggle into the system clock
    //--------------------------------------------------------------------------
    // Stage 0 feeds only stage 1; the edge is taken between 1 and 2
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            togSync_r <= 3'h0;
        end else begin
            togSync_r <= {togSync_r[1:0], wordTog_r};
        end
    end

    assign wordEv = togSync_r[2] ^ togSync_r[1];

    // Held word is stable for a full word time after its toggle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pendV_r    <= 1'b0;
            pendData_r <= '0;
        end else if (wordEv) begin
            pendV_r    <= 1'b1;
            pendData_r <= {holdFirst_r, wordHold_r};
        end else if (fifoInReady) begin
            pendV_r    <= 1'b0;
        end
    end

    tkp_word_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (mclk),
        .nrst     (nrst),
        .inValid  (pendV_r),
        .inReady  (fifoInReady),
        .inData   (pendData_r),
        .outValid (fifoOutValid),
        .outReady (drainReady),
        .outData  (fifoOut)
    );

    //--------------------------------------------------------------------------
    // Command decode and frame state
    //--------------------------------------------------------------------------
    // Converter result writes take the map; host words wait while resWe is high
    assign drainReady = !resWe;
    assign take       = fifoOutValid && drainReady;
    assign isFirst    = fifoOut[FIRST_BIT];
    assign hostWord   = fifoOut[DATA_W-1:0];
    assign hostWe     = take && !isFirst && state_r == ST_WRITE;
    assign shipClr    = take && !isFirst && state_r == ST_READ && armed_r;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
            ptr_r   <= '0;
        end else if (take) begin
            if (isFirst) begin
                state_r <= hostWord[CMD_READ_BIT] ? ST_READ : ST_WRITE;
                ptr_r   <= hostWord[ADDR_W-1:0] + 4'h1;
                if (!hostWord[CMD_READ_BIT]) begin
                    ptr_r <= hostWord[ADDR_W-1:0];
                end
            end else begin
                case (state_r)
                    ST_WRITE: ptr_r <= ptr_r + 4'h1;
                    ST_READ:  ptr_r <= ptr_r + 4'h1;
                    default:  ptr_r <= ptr_r;
                endcase
            end
        end
    end

    // Prefetch: word k+1 is ready long before its boundary
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdWord_r <= REG_RST;
        end else if (take && isFirst && hostWord[CMD_READ_BIT]) begin
            rdWord_r <= regs_r[hostWord[ADDR_W-1:0]];
        end else if (take && !isFirst && state_r == ST_READ) begin
            rdWord_r <= regs_r[ptr_r];
        end else if (take && isFirst) begin
            rdWord_r <= REG_RST;
        end
    end

    // Tracks which address has fully left on the wire; the turnaround
    // word after a read command ships nothing
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            shipAddr_r <= '0;
            armed_r    <= 1'b0;
        end else if (take && isFirst) begin
            shipAddr_r <= hostWord[ADDR_W-1:0];
            armed_r    <= 1'b0;
        end else if (take && state_r == ST_READ) begin
            armed_r <= 1'b1;
            if (armed_r) begin
                shipAddr_r <= shipAddr_r + 4'h1;
            end
        end
    end

    //--------------------------------------------------------------------------
    // Register map: one entry per generate step
    //--------------------------------------------------------------------------
    for (genvar gi = 0; gi < REG_NUM; gi++) begin : g_reg
        always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
                regs_r[gi] <= REG_RST;
            end else if (resWe && resAddr == ADDR_W'(gi)) begin
                regs_r[gi] <= resData;
            end else if (hostWe && ptr_r == ADDR_W'(gi)) begin
                regs_r[gi] <= hostWord;
            end
        end
    end

    // Control words steer the analog side
    assign adcCtrl = regs_r[ADC_CTRL_IDX];
    assign dacCtrl = regs_r[DAC_CTRL_IDX];
    assign keyCtrl = regs_r[KEY_CTRL_IDX];

    //--------------------------------------------------------------------------
    // Event outputs; a new event wins over a same-cycle clear
    //--------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dataRdy_r <= 1'b0;
        end else if (convDone) begin
            dataRdy_r <= 1'b1;
        end else if (shipClr && shipAddr_r >= RES_BASE_IDX) begin
            dataRdy_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            keyFlag_r <= 1'b0;
        end else if (keyHit) begin
            keyFlag_r <= 1'b1;
        end else if (shipClr && shipAddr_r == KEY_CODE_IDX) begin
            keyFlag_r <= 1'b0;
        end
    end

    // Touch follows the detector level, one flop late
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            touch_r <= 1'b0;
        end else begin
            touch_r <= touchIn;
        end
    end

    assign resultReadyN   = ~dataRdy_r;
    assign keyPressIrqN   = ~keyFlag_r;
    assign touchDetectIrq = touch_r;

    //--------------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------------
    chk_miso_float: assert property (@(posedge mclk) disable iff (!nrst)
        ssN |-> misoOeN && !misoOut)
        else $error("serial output driven while deselected");

    chk_no_capture: assert property (@(posedge mclk) disable iff (!nrst)
        ssN |-> bitCnt_r == BIT_CNT_RST) else $error("bit count moved while deselected");

    chk_in_sample: assert property (@(negedge sclk) disable iff (ssN)
        (bitCnt_r != BIT_CNT_RST) |-> shIn_r[0] == $past(mosi))
        else $error("input bit not taken on falling edge");

    chk_out_shift: assert property (@(negedge sclk) disable iff (ssN)
        (bitCnt_r != BIT_CNT_RST && bitCnt_r != 4'h1) |-> shOut_r == ($past(shOut_r) << 1))
        else $error("output not shifted on falling edge");

    chk_word_pend: assert property (@(posedge mclk) disable iff (!nrst)
        wordEv |=> pendV_r && pendData_r[DATA_W-1:0] == $past(wordHold_r))
        else $error("completed word not queued");

    chk_cmd_decode: assert property (@(posedge mclk) disable iff (!nrst)
        (take && isFirst) |=> state_r == ($past(hostWord[CMD_READ_BIT]) ? ST_READ : ST_WRITE))
        else $error("command word not decoded");

    chk_ready_set: assert property (@(posedge mclk) disable iff (!nrst)
        convDone |=> !resultReadyN) else $error("result ready not asserted");

    chk_key_set: assert property (@(posedge mclk) disable iff (!nrst)
        keyHit |=> !keyPressIrqN ##1 (keyHit || !keyPressIrqN || $past(shipClr)))
        else $error("key interrupt not asserted");

    chk_touch_follow: assert property (@(posedge mclk) disable iff (!nrst)
        touchIn |=> touchDetectIrq) else $error("touch interrupt missing");

    chk_result_store: assert property (@(posedge mclk) disable iff (!nrst)
        resWe |=> regs_r[$past(resAddr)] == $past(resData))
        else $error("result not stored");

    chk_ctrl_write: assert property (@(posedge mclk) disable iff (!nrst)
        (hostWe && ptr_r == ADC_CTRL_IDX) |=> adcCtrl == $past(hostWord))
        else $error("control word not applied");

    cov_read_cmd:  cover property (@(posedge mclk) take && isFirst && hostWord[CMD_READ_BIT]);
    cov_write_reg: cover property (@(posedge mclk) hostWe);
    cov_fifo_full: cover property (@(posedge mclk) pendV_r && !fifoInReady);
    cov_conv_read: cover property (@(posedge mclk) dataRdy_r ##[1:1000] !dataRdy_r);

endmodule : touch_keypad_serial_host_port

/* host_spi_model.sv */
// Host-side serial master model that makes the link clock and select
`timescale 1ns/10ps
module host_spi_model (
    output logic      sclk,
    output logic      ssN,
    output logic      mosi,
    input  wire logic miso
);
    logic [15:0] rxWord [0:4];  // Words seen on the data output in the last frame

    //--------------------------------------------------------------------------
    // Frame driver
    //--------------------------------------------------------------------------
    // Clock parks high; outside frames only glitch moves it
    initial begin
        sclk = 1'b1;
        ssN  = 1'b1;
        mosi = 1'b0;
    end

    // Select stays low for the whole frame, command word goes first
    task automatic frame(input int n, input logic [15:0] tx [0:4]);
        ssN = 1'b0;
        #15;
        for (int w = 0; w < n; w++) begin
            for (int b = 15; b >= 0; b--) begin
                mosi = tx[w][b];      // MSB first, 16 bits a word
                rxWord[w][b] = miso;  // Bit launched on the previous fall
                #7.5 sclk = 1'b0;     // Device takes this bit and launches the next
                #7.5 sclk = 1'b1;
            end
        end
        #15 ssN = 1'b1;
        mosi = ~mosi;  // No hold on the line after a frame
        #40;           // Gap before a next select must exceed 6 mclk
    endtask : frame

    // Clock and data wiggle while deselected, on the bench's command
    task automatic glitch();
        for (int i = 0; i < 8; i++) begin
            mosi = ~mosi;
            #7.5 sclk = 1'b0;
            #7.5 sclk = 1'b1;
        end
        #30;
    endtask : glitch
endmodule : host_spi_model

/* tb_top.sv */
// Self-checking bench for the touch and keypad serial host port
`timescale 1ns/10ps
module tb_top;
    import tkp_pkg::*;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] data;
    } row_s;

    logic              mclk, nrst, sclk, ssN, mosi, misoOut, misoOeN;
    logic              convDone, keyHit, touchIn, resWe;
    logic [ADDR_W-1:0] resAddr;
    logic [DATA_W-1:0] resData, adcCtrl, dacCtrl, keyCtrl, seen;
    logic              resultReadyN, keyPressIrqN, touchDetectIrq;
    wire               misoWire = misoOeN ? 1'bz : misoOut;  // Pin seen by the host
    int                fails = 0;
    int                n_checks = 0;
    row_s              rows [0:3] = '{'{4'h0, 16'hA5C3}, '{4'h1, 16'hFFFF},
                                      '{4'h2, 16'h8001}, '{4'h1, 16'h0000}};

    //--------------------------------------------------------------------------
    // Design, host model and clock
    //--------------------------------------------------------------------------
    touch_keypad_serial_host_port dut_u (
        .mclk(mclk), .nrst(nrst), .sclk(sclk), .ssN(ssN), .mosi(mosi),
        .misoOut(misoOut), .misoOeN(misoOeN), .convDone(convDone),
        .keyHit(keyHit), .touchIn(touchIn), .resWe(resWe), .resAddr(resAddr),
        .resData(resData), .adcCtrl(adcCtrl), .dacCtrl(dacCtrl),
        .keyCtrl(keyCtrl), .resultReadyN(resultReadyN),
        .keyPressIrqN(keyPressIrqN), .touchDetectIrq(touchDetectIrq)
    );

    host_spi_model hostU (.sclk(sclk), .ssN(ssN), .mosi(mosi), .miso(misoWire));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    //--------------------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One frame, then room for the word to cross and land
    task automatic xfer(input int n, input logic [15:0] w0, w1, w2, w3, w4);
        logic [15:0] tx [0:4];
        tx = '{w0, w1, w2, w3, w4};
        hostU.frame(n, tx);
        repeat (12) @(posedge mclk);
        #1;
    endtask : xfer

    task automatic pulse(input int which);
        @(posedge mclk);
        if (which == 0) convDone <= 1'b1; else keyHit <= 1'b1;
        @(posedge mclk);
        convDone <= 1'b0;
        keyHit   <= 1'b0;
        #1;
    endtask : pulse

    task automatic resWrite(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        resWe   <= 1'b1;
        resAddr <= a;
        resData <= d;
        @(posedge mclk);
        resWe   <= 1'b0;
    endtask : resWrite

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    // Whole run is some 10 us; anything far past that is a hang
    initial begin
        #100000;
        fails++;
        end_of_test();
    end

    //--------------------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------------------
    initial begin
        {nrst, convDone, keyHit, touchIn, resWe} = '0;
        resAddr = '0;
        resData = '0;
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        chk("adcCtrl", 16'h0000, adcCtrl);
        chk("resultReadyN", 16'h0001, resultReadyN);
        chk("keyPressIrqN", 16'h0001, keyPressIrqN);
        chk("touchDetectIrq", 16'h0000, touchDetectIrq);
        chk("misoOeN idle", 16'h0001, misoOeN);
        // Single-word writes; each control word reaches its output
        foreach (rows[i]) begin
            xfer(2, {12'h000, rows[i].addr}, rows[i].data, 16'h0, 16'h0, 16'h0);
            seen = (rows[i].addr == 4'h0) ? adcCtrl : (rows[i].addr == 4'h1) ? dacCtrl : keyCtrl;
            chk("ctrl row", rows[i].data, seen);
        end
        // Burst from the top address wraps round to 0
        xfer(4, 16'h000F, 16'h1111, 16'h2222, 16'h3333, 16'h0);
        chk("adcCtrl wrap", 16'h2222, adcCtrl);
        chk("dacCtrl wrap", 16'h3333, dacCtrl);
        // Read back: cmd, turnaround, then three registers
        fork
            xfer(5, 16'h8000, 16'h0, 16'h0, 16'h0, 16'h0);
            begin
                #100;
                chk("misoOeN busy", 16'h0000, misoOeN);
            end
        join
        chk("rx first", 16'h0000, hostU.rxWord[0]);
        chk("rx reg0", 16'h2222, hostU.rxWord[2]);
        chk("rx reg1", 16'h3333, hostU.rxWord[3]);
        chk("rx reg2", 16'h8001, hostU.rxWord[4]);
        // Deselected clocking must leave everything alone
        hostU.glitch();
        chk("adcCtrl glitch", 16'h2222, adcCtrl);
        xfer(2, 16'h0002, 16'h0F0F, 16'h0, 16'h0, 16'h0);
        chk("keyCtrl after", 16'h0F0F, keyCtrl);
        // Results and events
        resWrite(4'h8, 16'h1234);
        resWrite(4'h9, 16'h5678);
        resWrite(4'h3, 16'h00A5);
        pulse(0);
        chk("resultReadyN set", 16'h0000, resultReadyN);
        pulse(1);
        chk("keyPressIrqN set", 16'h0000, keyPressIrqN);
        xfer(4, 16'h8008, 16'h0, 16'h0, 16'h0, 16'h0);
        chk("rx reg8", 16'h1234, hostU.rxWord[2]);
        chk("rx reg9", 16'h5678, hostU.rxWord[3]);
        chk("resultReadyN clr", 16'h0001, resultReadyN);
        chk("keyPressIrqN kept", 16'h0000, keyPressIrqN);
        xfer(4, 16'h8003, 16'h0, 16'h0, 16'h0, 16'h0);
        chk("rx key code", 16'h00A5, hostU.rxWord[2]);
        chk("keyPressIrqN clr", 16'h0001, keyPressIrqN);
        @(posedge mclk);
        touchIn <= 1'b1;
        @(posedge mclk);
        #1;
        chk("touchDetectIrq on", 16'h0001, touchDetectIrq);
        @(posedge mclk);
        touchIn <= 1'b0;
        @(posedge mclk);
        #1;
        chk("touchDetectIrq off", 16'h0000, touchDetectIrq);
        // Result port held busy: host words wait in the FIFO
        @(posedge mclk);
        resWe   <= 1'b1;
        resAddr <= 4'hE;
        resData <= 16'hBEEF;
        xfer(4, 16'h0000, 16'h0101, 16'h0202, 16'h0303, 16'h0);
        chk("adcCtrl stalled", 16'h2222, adcCtrl);
        @(posedge mclk);
        resWe <= 1'b0;
        repeat (20) @(posedge mclk);
        #1;
        chk("adcCtrl drained", 16'h0101, adcCtrl);
        chk("dacCtrl drained", 16'h0202, dacCtrl);
        chk("keyCtrl drained", 16'h0303, keyCtrl);
        // Reset in mid-run clears at once
        pulse(0);
        nrst <= 1'b0;
        #2;
        chk("adcCtrl rst", 16'h0000, adcCtrl);
        chk("resultReadyN rst", 16'h0001, resultReadyN);
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        xfer(2, 16'h0001, 16'h00FF, 16'h0, 16'h0, 16'h0);
        chk("dacCtrl after rst", 16'h00FF, dacCtrl);
        end_of_test();
    end
endmodule : tb_top
